// File: rtl/edmi_top.sv
`timescale 1ns/1ps
`include "edmi_params.svh"

module edmi_top (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// register bus
	input  wire logic [11:0]      s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [11:0]      s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// external-move requests from the core
	input  wire edmi_pkg::edmi_req_t req,
	input  wire logic             req_valid,
	output logic                  req_ready,
	output logic                  req_done,
	output logic [7:0]            req_rdata,
	// port pins, eight ports, lower bank in bits 31:0
	input  wire logic [63:0]      pin_i,
	output logic [63:0]           pin_o,
	output logic [63:0]           pin_oe,
	output logic [63:0]           pin_claim,
	input  wire logic [63:0]      port_latch,
	input  wire logic [63:0]      port_latch_oe,
	// crossbar
	input  wire logic             crossbar_strobe_skip,
	output logic [7:0]            crossbar_skip_mask
);

	edmi_pkg::edmi_regs_t q;
	edmi_pkg::edmi_regs_t d;

	logic [7:0]  ram [0:`EDMI_RAM_WORDS-1];
	logic [7:0]  ram_q;
	logic        req_fire;
	logic [15:0] eff_addr;
	logic        off_now;
	logic        hi_now;
	logic        ram_we;
	logic [1:0]  mode;
	logic [1:0]  ale_code;
	logic        bank_hi;
	logic        muxed;
	logic        wr_fire;
	logic        rd_fire;
	logic [9:0]  wr_idx;
	logic [9:0]  rd_idx;
	logic [31:0] bank_o;
	logic [31:0] bank_oe;
	logic [31:0] bank_claim;
	logic [31:0] bank_in;
	logic        off_busy;

	// effective address from page and index, or the full pointer
	function automatic logic [15:0] edmi_eff(
		input edmi_pkg::edmi_req_t r,
		input logic [7:0]          page
	);
		edmi_eff = r.wide ? r.pointer : {page, r.index};
	endfunction

	// place one bank's bits into the lower or upper half of the pins
	function automatic logic [63:0] edmi_place(
		input logic [31:0] v,
		input logic        hi
	);
		edmi_place = hi ? {v, 32'h0000_0000} : {32'h0000_0000, v};
	endfunction

	assign mode     = q.cfg[`EDMI_CFG_MODE_HI:`EDMI_CFG_MODE_LO];
	assign ale_code = q.cfg[`EDMI_CFG_ALE_HI:`EDMI_CFG_ALE_LO];
	assign bank_hi  = q.cfg[`EDMI_CFG_BANK_BIT];
	assign muxed    = ~q.cfg[`EDMI_CFG_SPLIT_BIT];

	// routing decision, made on the whole address before any pin moves
	always_comb
	begin
		eff_addr = edmi_eff(req, q.page);
		unique case (mode)
			`EDMI_MODE_INTERNAL: off_now = 1'b0;
			`EDMI_MODE_EXTERNAL: off_now = 1'b1;
			default: off_now = (eff_addr >= `EDMI_ONCHIP_TOP);
		endcase
		// short access in modes 01 and 11 leaves A15:8 to the latches
		hi_now = req.wide || (mode == `EDMI_MODE_SPLIT_BS);
	end

	assign req_ready = (q.st == edmi_pkg::S_IDLE);
	assign req_fire  = req_valid & req_ready;
	assign ram_we    = req_fire & ~off_now & req.write;

	// on-chip store; only 13 address bits so higher pages wrap
	always_ff @(posedge aclk)
	begin
		if (ram_we)
			ram[eff_addr[12:0]] <= req.wdata;
		ram_q <= ram[eff_addr[12:0]];
	end

	// register bus decode; words are aligned, index is byte address / 4
	assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
	assign rd_fire = s_axi_arvalid & ~q.rvalid;
	assign wr_idx  = s_axi_awaddr[11:2];
	assign rd_idx  = s_axi_araddr[11:2];
	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign s_axi_arready = ~q.rvalid;

	// only the low lane carries the eight-bit registers
	always_comb
	begin
		d = q;
		d.done = 1'b0;
		d.pin_s1 = pin_i;
		d.pin_s2 = q.pin_s1;
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (wr_fire)
		begin
			d.bvalid = 1'b1;
			d.bresp  = `EDMI_RESP_OKAY;
			if (wr_idx == {2'h0, `EDMI_CFG_IDX})
			begin
				if (s_axi_wstrb[0])
					d.cfg = s_axi_wdata[5:0];
			end
			else if (wr_idx == {2'h0, `EDMI_PAGE_IDX})
			begin
				if (s_axi_wstrb[0])
					d.page = s_axi_wdata[7:0];
			end
			else
				d.bresp = `EDMI_RESP_SLVERR;
		end
		if (rd_fire)
		begin
			d.rvalid = 1'b1;
			d.rresp  = `EDMI_RESP_OKAY;
			if (rd_idx == {2'h0, `EDMI_CFG_IDX})
				d.rbyte = {2'h0, q.cfg};
			else if (rd_idx == {2'h0, `EDMI_PAGE_IDX})
				d.rbyte = q.page;
			else
			begin
				d.rbyte = 8'h00;
				d.rresp = `EDMI_RESP_SLVERR;
			end
		end

		// access sequencer; cnt counts down the clocks left in a phase
		unique case (q.st)
			edmi_pkg::S_IDLE:
			begin
				if (req_fire)
				begin
					d.write    = req.write;
					d.wdata    = req.wdata;
					d.addr     = eff_addr;
					d.drive_hi = hi_now;
					if (!off_now)
						d.st = edmi_pkg::S_RAM;
					else if (muxed)
					begin
						d.st  = edmi_pkg::S_ALE_HI;
						d.cnt = {1'b0, ale_code};
					end
					else
					begin
						d.st  = edmi_pkg::S_SETUP;
						d.cnt = `EDMI_SETUP_CYC - 3'h1;
					end
				end
			end
			edmi_pkg::S_RAM:
			begin
				d.rdata = ram_q;
				d.done  = 1'b1;
				d.st    = edmi_pkg::S_IDLE;
			end
			edmi_pkg::S_ALE_HI:
			begin
				if (q.cnt == 3'h0)
				begin
					d.st  = edmi_pkg::S_ALE_LO;
					d.cnt = {1'b0, ale_code};
				end
				else
					d.cnt = q.cnt - 3'h1;
			end
			edmi_pkg::S_ALE_LO:
			begin
				if (q.cnt == 3'h0)
				begin
					d.st  = edmi_pkg::S_SETUP;
					d.cnt = `EDMI_SETUP_CYC - 3'h1;
				end
				else
					d.cnt = q.cnt - 3'h1;
			end
			edmi_pkg::S_SETUP:
			begin
				if (q.cnt == 3'h0)
				begin
					d.st  = edmi_pkg::S_STROBE;
					d.cnt = `EDMI_STROBE_CYC - 3'h1;
				end
				else
					d.cnt = q.cnt - 3'h1;
			end
			edmi_pkg::S_STROBE:
			begin
				if (q.cnt == 3'h0)
				begin
					d.st  = edmi_pkg::S_HOLD;
					d.cnt = `EDMI_HOLD_CYC - 3'h1;
				end
				else
					d.cnt = q.cnt - 3'h1;
			end
			edmi_pkg::S_HOLD:
			begin
				// sample late: the pins pass two sync stages first
				if (q.cnt == 3'h0)
				begin
					d.rdata = bank_in[`EDMI_DAT_BYTE*8 +: 8];
					d.done  = 1'b1;
					d.st    = edmi_pkg::S_IDLE;
				end
				else
					d.cnt = q.cnt - 3'h1;
			end
		endcase
	end

	// single register for all sequencer and bus state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q        <= '0;
			q.cfg    <= `EDMI_CFG_RESET;
			q.page   <= `EDMI_PAGE_RESET;
			q.st     <= edmi_pkg::S_IDLE;
		end
		else
			q <= d;
	end

	assign off_busy = (q.st != edmi_pkg::S_IDLE) && (q.st != edmi_pkg::S_RAM);
	assign bank_in  = bank_hi ? q.pin_s2[63:32] : q.pin_s2[31:0];

	// pin values for the active bank; write and read strobes are active low, latch strobe active high
	always_comb
	begin
		bank_o     = '0;
		bank_oe    = '0;
		bank_claim = '0;
		if (off_busy)
		begin
			bank_o[`EDMI_CTL_BYTE*8 + `EDMI_WR_BIT] =
				~(q.write && q.st == edmi_pkg::S_STROBE);
			bank_o[`EDMI_CTL_BYTE*8 + `EDMI_RD_BIT] =
				~(!q.write && q.st == edmi_pkg::S_STROBE);
			bank_o[`EDMI_CTL_BYTE*8 + `EDMI_ALE_BIT] =
				(q.st == edmi_pkg::S_ALE_HI);
			bank_claim[`EDMI_CTL_BYTE*8 + `EDMI_WR_BIT] = 1'b1;
			bank_claim[`EDMI_CTL_BYTE*8 + `EDMI_RD_BIT] = 1'b1;
			bank_claim[`EDMI_CTL_BYTE*8 + `EDMI_ALE_BIT] = muxed;
			bank_oe[`EDMI_CTL_BYTE*8 + `EDMI_WR_BIT] = 1'b1;
			bank_oe[`EDMI_CTL_BYTE*8 + `EDMI_RD_BIT] = 1'b1;
			bank_oe[`EDMI_CTL_BYTE*8 + `EDMI_ALE_BIT] = muxed;
			// upper address left to the latches unless ordered to drive
			if (q.drive_hi)
			begin
				bank_o[`EDMI_AHI_BYTE*8 +: 8]     = q.addr[15:8];
				bank_oe[`EDMI_AHI_BYTE*8 +: 8]    = 8'hFF;
				bank_claim[`EDMI_AHI_BYTE*8 +: 8] = 8'hFF;
			end
			bank_claim[`EDMI_DAT_BYTE*8 +: 8] = 8'hFF;
			if (muxed)
			begin
				// shared pins: address while latch strobe high, then data
				if (q.st == edmi_pkg::S_ALE_HI)
				begin
					bank_o[`EDMI_DAT_BYTE*8 +: 8]  = q.addr[7:0];
					bank_oe[`EDMI_DAT_BYTE*8 +: 8] = 8'hFF;
				end
				else if (q.write && q.st != edmi_pkg::S_ALE_LO)
				begin
					bank_o[`EDMI_DAT_BYTE*8 +: 8]  = q.wdata;
					bank_oe[`EDMI_DAT_BYTE*8 +: 8] = 8'hFF;
				end
			end
			else
			begin
				bank_o[`EDMI_ALO_BYTE*8 +: 8]     = q.addr[7:0];
				bank_oe[`EDMI_ALO_BYTE*8 +: 8]    = 8'hFF;
				bank_claim[`EDMI_ALO_BYTE*8 +: 8] = 8'hFF;
				bank_o[`EDMI_DAT_BYTE*8 +: 8]     = q.wdata;
				bank_oe[`EDMI_DAT_BYTE*8 +: 8]    = {8{q.write}};
			end
		end
	end

	// unclaimed pins fall back to the port latches; output mode
	// stays with the port logic, only enables are produced here
	assign pin_claim = edmi_place(bank_claim, bank_hi);
	assign pin_o  = (edmi_place(bank_o, bank_hi) & pin_claim)
		| (port_latch & ~pin_claim);
	assign pin_oe = (edmi_place(bank_oe, bank_hi) & pin_claim)
		| (port_latch_oe & ~pin_claim);

	// crossbar skips the strobe pins of port 0 in the lower bank
	assign crossbar_skip_mask = (crossbar_strobe_skip && !bank_hi) ?
		{2'h3, muxed, 5'h00} : 8'h00;

	assign req_done    = q.done;
	assign req_rdata   = q.rdata;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp  = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp  = q.rresp;
	assign s_axi_rdata  = {24'h000000, q.rbyte};

	AST_CFG_RESET: assert property (@(posedge aclk)
		$rose(aresetn) |-> q.cfg == `EDMI_CFG_RESET)
		else $error("configuration reset value wrong");
	AST_CLAIM_ONLY_OFF: assert property (@(posedge aclk)
		disable iff (!aresetn) (pin_claim != 64'h0) |-> off_busy)
		else $error("pins claimed outside an off-chip access");
	AST_READ_DATA_OFF: assert property (@(posedge aclk)
		disable iff (!aresetn) (off_busy && !q.write && !muxed)
		|-> bank_oe[`EDMI_DAT_BYTE*8 +: 8] == 8'h00)
		else $error("data driven during read");
	AST_INTERNAL_WRAP: assert property (@(posedge aclk)
		disable iff (!aresetn) (req_fire && mode == `EDMI_MODE_INTERNAL)
		|=> q.st == edmi_pkg::S_RAM)
		else $error("internal mode went off-chip");
	AST_EXTERNAL_ONLY: assert property (@(posedge aclk)
		disable iff (!aresetn) (req_fire && mode == `EDMI_MODE_EXTERNAL)
		|=> q.st != edmi_pkg::S_RAM && q.drive_hi == $past(req.wide))
		else $error("external mode routing wrong");
	AST_SPLIT_BOUNDARY: assert property (@(posedge aclk)
		disable iff (!aresetn) (req_fire && mode[0] != mode[1])
		|=> (q.st == edmi_pkg::S_RAM) == (q.addr < 16'h2000))
		else $error("split decision wrong");
	AST_NONMUX_FIVE: assert property (@(posedge aclk)
		disable iff (!aresetn) (req_fire && off_now && !muxed)
		|-> !req_done [*6] ##1 req_done)
		else $error("non-multiplexed access not five clocks");
	AST_MUX_SEVEN: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(req_fire && off_now && muxed && ale_code == 2'h0)
		|-> !req_done [*8] ##1 req_done)
		else $error("multiplexed access not seven clocks");
	AST_ALE_ADDRESS: assert property (@(posedge aclk)
		disable iff (!aresetn) (q.st == edmi_pkg::S_ALE_HI)
		|-> bank_o[`EDMI_DAT_BYTE*8 +: 8] == q.addr[7:0]
		&& bank_o[`EDMI_CTL_BYTE*8 + `EDMI_ALE_BIT])
		else $error("latch strobe phase wrong");
	AST_NO_BANK_HIGH: assert property (@(posedge aclk)
		disable iff (!aresetn) (off_busy && !q.drive_hi)
		|-> bank_claim[`EDMI_AHI_BYTE*8 +: 8] == 8'h00)
		else $error("upper address driven without bank select");
	AST_BANK_SIDE: assert property (@(posedge aclk)
		disable iff (!aresetn) bank_hi |-> pin_claim[31:0] == 32'h0)
		else $error("lower bank used while upper selected");
	AST_SKIP_MASK: assert property (@(posedge aclk)
		disable iff (!aresetn) (crossbar_strobe_skip && !bank_hi)
		|-> crossbar_skip_mask[7:6] == 2'h3)
		else $error("strobe pins not skipped");

endmodule

// File: rtl/edmi_params.svh
`ifndef EDMI_PARAMS_SVH
`define EDMI_PARAMS_SVH

// register indices; byte address is four times the index
`define EDMI_CFG_IDX        8'hA3
`define EDMI_PAGE_IDX       8'hA4
`define EDMI_CFG_RESET      6'h03
`define EDMI_PAGE_RESET     8'h00
// configuration field positions
`define EDMI_CFG_BANK_BIT   5
`define EDMI_CFG_SPLIT_BIT  4
`define EDMI_CFG_MODE_HI    3
`define EDMI_CFG_MODE_LO    2
`define EDMI_CFG_ALE_HI     1
`define EDMI_CFG_ALE_LO     0
// memory map
`define EDMI_ONCHIP_TOP     16'h2000
`define EDMI_RAM_WORDS      8192
`define EDMI_MODE_INTERNAL  2'h0
`define EDMI_MODE_SPLIT_NB  2'h1
`define EDMI_MODE_SPLIT_BS  2'h2
`define EDMI_MODE_EXTERNAL  2'h3
// pin layout inside one four-port bank
`define EDMI_CTL_BYTE       0
`define EDMI_ALO_BYTE       1
`define EDMI_AHI_BYTE       2
`define EDMI_DAT_BYTE       3
`define EDMI_WR_BIT         7
`define EDMI_RD_BIT         6
`define EDMI_ALE_BIT        5
`define EDMI_BANK_W         32
// access phases in system clocks
`define EDMI_SETUP_CYC      3'h2
`define EDMI_STROBE_CYC     3'h1
`define EDMI_HOLD_CYC       3'h2
// bus answers
`define EDMI_RESP_OKAY      2'h0
`define EDMI_RESP_SLVERR    2'h2

`endif

// File: rtl/edmi_pkg.sv
package edmi_pkg;

	typedef enum logic [2:0] {
		S_IDLE,
		S_RAM,
		S_ALE_HI,
		S_ALE_LO,
		S_SETUP,
		S_STROBE,
		S_HOLD
	} edmi_state_t;

	// one external-move request from the core
	typedef struct packed {
		logic        wide;
		logic        write;
		logic [7:0]  index;
		logic [15:0] pointer;
		logic [7:0]  wdata;
	} edmi_req_t;

	typedef struct packed {
		logic [5:0]  cfg;
		logic [7:0]  page;
		edmi_state_t st;
		logic [2:0]  cnt;
		logic        write;
		logic        drive_hi;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic        done;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [7:0]  rbyte;
		logic [63:0] pin_s1;
		logic [63:0] pin_s2;
	} edmi_regs_t;

endpackage

// File: bench/edmi_sram.sv
`timescale 1ns/1ps

module edmi_sram (
	input  wire logic        aclk,
	input  wire logic        bank_hi,
	input  wire logic        muxed,
	input  wire logic [63:0] pin_o,
	input  wire logic [63:0] pin_oe,
	output logic      [63:0] pin_i
);
	logic [7:0]  mem [0:65535];
	logic [31:0] bank;
	logic [31:0] boe;
	logic [7:0]  alat;
	logic [15:0] addr;
	logic        drive;
	int          n_writes = 0;

	// view of the four ports that carry the bus
	assign bank  = bank_hi ? pin_o[63:32] : pin_o[31:0];
	assign boe   = bank_hi ? pin_oe[63:32] : pin_oe[31:0];
	assign addr  = {bank[23:16], muxed ? alat : bank[15:8]};
	assign drive = !bank[6] && boe[6];

	// follows while strobe high, frozen after it falls
	always_latch
		if (bank[5] && boe[5]) alat <= bank[31:24];

	// undriven pins read inverted, so a stale value cannot pass
	always_comb
	begin
		pin_i = (pin_o & pin_oe) | (~pin_o & ~pin_oe);
		if (drive && bank_hi) pin_i[63:56] = mem[addr];
		if (drive && !bank_hi) pin_i[31:24] = mem[addr];
	end

	// write strobe lasts one clock, so one store per access
	always_ff @(posedge aclk)
		if (!bank[7] && boe[7])
		begin
			mem[addr] <= bank[31:24];
			n_writes  <= n_writes + 1;
		end
endmodule

// File: bench/edmi_bench.sv
`timescale 1ns/1ps
`include "edmi_params.svh"

module external_data_memory_interface_bench;
	localparam logic [11:0] A_CFG = {2'b00, `EDMI_CFG_IDX, 2'b00};
	localparam logic [11:0] A_PG  = {2'b00, `EDMI_PAGE_IDX, 2'b00};
	localparam logic [1:0]  OK    = `EDMI_RESP_OKAY;
	logic                aclk, aresetn, awv, wv, bready, arv, rready;
	logic                awr, wr, bv, arr, rv, reqv, rdy, done, skip;
	logic [11:0]         awaddr, araddr;
	logic [31:0]         wdata, rdata;
	logic [1:0]          bresp, rresp;
	logic [7:0]          rbyte, mask, page, d;
	logic [5:0]          cfg;
	logic [15:0]         a, pa;
	logic [63:0]         pin_i, pin_o, pin_oe, claim, latch, latch_oe;
	logic                w, on;
	edmi_pkg::edmi_req_t req;
	integer              seed, n_fail, n_tests, i, k, wc, cyc;

	edmi_top u_edmi_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rready), .req(req),
		.req_valid(reqv), .req_ready(rdy), .req_done(done),
		.req_rdata(rbyte), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
		.pin_claim(claim), .port_latch(latch), .port_latch_oe(latch_oe),
		.crossbar_strobe_skip(skip), .crossbar_skip_mask(mask));

	edmi_sram u_edmi_sram (.aclk(aclk), .bank_hi(cfg[5]), .muxed(!cfg[4]),
		.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// a wait that ran out ends the run as a mismatch
	task automatic hang;
		n_fail++;
		stop_test;
	endtask

	task automatic axi_wr(input logic [11:0] ad, input logic [31:0] dt);
		int t;
		t = 0;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= dt;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do @(negedge aclk); while (awr !== 1'b1 && ++t < 50);
		@(posedge aclk);
		awv <= 1'b0;
		wv <= 1'b0;
		while (bv !== 1'b1 && ++t < 50) @(negedge aclk);
		check(bresp, OK);
		@(posedge aclk);
		bready <= 1'b0;
		if (t >= 50) hang;
	endtask

	task automatic axi_rd(input logic [11:0] ad, input logic [31:0] ed,
		input logic [1:0] er);
		int t;
		t = 0;
		@(posedge aclk);
		araddr <= ad;
		arv <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arr !== 1'b1 && ++t < 50);
		@(posedge aclk);
		arv <= 1'b0;
		while (rv !== 1'b1 && ++t < 50) @(negedge aclk);
		check(rdata, ed);
		check(rresp, er);
		@(posedge aclk);
		rready <= 1'b0;
		if (t >= 50) hang;
	endtask

	// one move request; pins watched every cycle until done
	task automatic do_req(input logic wi, input logic wt,
		input logic [15:0] ea, input logic [7:0] dt);
		int n, ale, b;
		n = 0;
		ale = 0;
		b = cfg[5] * 32;
		@(posedge aclk);
		req <= '{wide: wi, write: wt, index: ea[7:0], pointer: ea, wdata: dt};
		reqv <= 1'b1;
		@(posedge aclk);
		reqv <= 1'b0;
		do
		begin
			@(negedge aclk);
			n++;
			ale += pin_o[b+5] & claim[b+5];
			check(claim[63-b -: 32], 0);
			check((pin_o ^ latch) & ~claim, 0);
			check((pin_oe ^ latch_oe) & ~claim, 0);
			if (!wt && cfg[4])
				check(pin_oe[b+24 +: 8] & claim[b+24 +: 8], 0);
			if (on) check(claim, 0);
		end while (done !== 1'b1 && n < 60);
		if (n >= 60) hang;
		check(n, cyc);
		check(rdy, 1'b1);
		if (!cfg[4] && !on) check(ale, cfg[1:0] + 1);
		if (!wt) check(rbyte, dt);
	endtask

	// location decided from the whole effective address
	function automatic logic f_on(input logic [1:0] m, input logic [15:0] x);
		return m == 2'h0 || (m != 2'h3 && x < 16'h2000);
	endfunction

	// address seen on the pins; high byte from latches where undriven
	function automatic logic [15:0] f_pa(input logic wi, input logic [15:0] x);
		if (wi || cfg[3:2] == 2'h2) return x;
		return {cfg[5] ? latch[55:48] : latch[23:16], x[7:0]};
	endfunction

	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	initial
	begin
		{awv, wv, bready, arv, rready, reqv, skip} = '0;
		{awaddr, araddr, wdata, req, latch, latch_oe} = '0;
		{n_fail, n_tests} = '0;
		cfg = 6'h03;
		seed = 32'h9907;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(A_CFG, 32'h03, OK);
		axi_rd(A_PG, 32'h00, OK);
		axi_rd(12'h100, 32'h00, `EDMI_RESP_SLVERR);
		axi_wr(A_CFG, 32'hFF);
		axi_rd(A_CFG, 32'h3F, OK);
		for (i = 0; i < 48; i++)
		begin
			cfg = {$random(seed) % 4, i[1:0], i[3:2]};
			k = $random(seed) & 3;
			page = k == 0 ? 8'h1F : k == 1 ? 8'h20 : $random(seed);
			// park strobes idle: write and read high, latch strobe low
			latch <= ({$random(seed), $random(seed)}
				& ~64'h0000_00E0_0000_00E0) | 64'h0000_00C0_0000_00C0;
			latch_oe <= {$random(seed), $random(seed)};
			skip <= $random(seed);
			axi_wr(A_CFG, {26'h0, cfg});
			axi_wr(A_PG, {24'h0, page});
			axi_rd(A_CFG, {26'h0, cfg}, OK);
			axi_rd(A_PG, {24'h0, page}, OK);
			check(mask, skip && !cfg[5] ? {2'h3, !cfg[4], 5'h0} : 8'h0);
			for (k = 0; k < 4; k++)
			begin
				w = $random(seed);
				case (k)
					0: a = 16'h1FFF;
					1: a = 16'h2000;
					2: a = 16'h4000;
					default: a = $random(seed);
				endcase
				if (!w) a[15:8] = page;
				d = $random(seed);
				on = f_on(cfg[3:2], a);
				pa = f_pa(w, a);
				cyc = on ? 2 : cfg[4] ? 6 : 8 + 2 * cfg[1:0];
				wc = u_edmi_sram.n_writes;
				do_req(w, 1'b1, a, d);
				if (on) check(u_edmi_sram.n_writes, wc);
				else check(u_edmi_sram.mem[pa], d);
				if (on && cfg[3:2] == 2'h0 && w) a = a ^ 16'h6000;
				do_req(w, 1'b0, a, d);
			end
		end
		stop_test;
	end
endmodule
